// >>> verification/mfi_contacts.sv
// Switch contact model feeding the input terminals
`timescale 1ns/10ps
`default_nettype none
module mfi_contacts (
  input wire logic core_clk,
  input wire logic [5:0] closed,
  output logic [5:0] prog_input
);
  // Contacts settle one edge after the bench moves them
  always_ff @(posedge core_clk) begin
    prog_input <= closed;
  end
endmodule : mfi_contacts
`default_nettype wire

// >>> verification/mfi_decoder_asserts.sv
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
`default_nettype none
module mfi_decoder_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [5:0] prog_input,
  input wire logic [29:0] func_code,
  input wire logic keypad_reset,
  input wire logic factory_reset,
  input wire logic [29:0] factory_code,
  input wire logic [3:0] step_speed_sel,
  input wire logic ramp_hold,
  input wire logic [1:0] ramp_set_sel,
  input wire logic output_disable,
  input wire logic freq_up,
  input wire logic freq_down,
  input wire logic counter_clear,
  input wire logic [2:0] aux_motor_disable,
  input wire logic estop,
  input wire logic external_fault_code
);
  // ------------------------------------------------------------
  // Reference decode
  // ------------------------------------------------------------
  logic [24:0] act;
  logic [24:0] act_q;
  logic [1:0] age_q;
  logic [4:0] code;
  logic lvl;
  logic rdy;
  always_comb begin
    act = 25'h0;
    code = 5'h0;
    lvl = 1'b0;
    for (int i = 0; i < 6; i++) begin
      code = func_code[5*i +: 5];
      lvl = prog_input[i] ^ (code == 5'h0a || code == 5'h14);
      if (code != 5'h00 && code <= 5'h18) begin
        act[code] = act[code] | lvl;
      end
    end
  end
  // Outputs are zero just after release, so wait a few edges
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_q <= 25'h0;
      age_q <= 2'h0;
    end else begin
      act_q <= act;
      age_q <= age_q + {1'b0, age_q != 2'h3};
    end
  end
  assign rdy = age_q == 2'h3;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_step_select: assert property (
    rdy |-> step_speed_sel == act_q[4:1]) else $error("step select");
  a_ramp_select: assert property (
    rdy |-> ramp_set_sel == act_q[8:7]) else $error("ramp select");
  a_ramp_hold: assert property (
    rdy |-> ramp_hold == act_q[6]) else $error("ramp hold");
  a_base_block: assert property (
    rdy |-> output_disable == (act_q[9] | act_q[10]))
    else $error("base block");
  a_count_clear: assert property (
    rdy |-> counter_clear == act_q[13]) else $error("counter clear");
  a_aux_disable: assert property (
    rdy |-> aux_motor_disable == act_q[18:16]) else $error("aux disable");
  a_up_pulse: assert property (
    freq_up |-> act_q[11] && !act_q[12] ##1 !freq_up)
    else $error("up pulse");
  a_down_pulse: assert property (
    freq_down |-> act_q[12] && !act_q[11] ##1 !freq_down)
    else $error("down pulse");
  a_estop_set: assert property (
    rdy && (act_q[19] || act_q[20]) |-> estop && external_fault_code)
    else $error("estop set");
  a_estop_latch: assert property (
    rdy && estop && !keypad_reset && !act[5] |=> estop)
    else $error("estop latch");
  a_factory_codes: assert property (
    rdy && factory_reset |=>
    factory_code == {5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01})
    else $error("factory codes");
  c_up: cover property (freq_up);
  c_estop: cover property (rdy && estop);
  c_block: cover property (rdy && output_disable);
endmodule : mfi_decoder_asserts
`default_nettype wire

// >>> verification/mfi_decoder_test.sv
// Self-checking bench of the multi-function input decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module mfi_decoder_test;
  typedef struct packed {
    logic [29:0] fc;
    logic [5:0] cl;
    logic [3:0] step;
    logic [1:0] ramp;
    logic [2:0] aux;
    logic [3:0] flg;
  } mfi_row_type;
  // Flags: hold, disable, counter clear, terminal commands
  mfi_row_type rows [6] = '{
    {30'h0, 6'h3f, 4'h0, 2'h0, 3'h0, 4'h0},
    {5'h0d, 5'h06, 5'h04, 5'h03, 5'h02, 5'h01, 6'h3f, 13'h1e0a},
    {5'h08, 5'h07, 5'h04, 5'h03, 5'h02, 5'h01, 6'h35, 13'h0b80},
    {5'h12, 5'h11, 5'h10, 5'h0a, 5'h08, 5'h07, 6'h29, 13'h00d4},
    {5'h00, 5'h00, 5'h12, 5'h17, 5'h0a, 5'h09, 6'h07, 13'h0005},
    {5'h00, 5'h00, 5'h00, 5'h1f, 5'h04, 5'h04, 6'h06, 13'h1000}};
  logic [5:0] upd_pat [3] = '{6'h1, 6'h3, 6'h2};
  logic [1:0] src_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic core_clk = 1'b0, sys_rst = 1'b1;
  logic [5:0] closed = 6'h0;
  logic [5:0] prog_input;
  logic [29:0] func_code = 30'h0, analog_delay = 30'h0;
  logic factory_reset = 1'b0, fault_cleared = 1'b0, keypad_reset = 1'b0;
  logic speed_search_done = 1'b0, seq_running = 1'b0, param_cmd_ext = 1'b0;
  logic auto_ramp_param = 1'b1, bipolar_mode = 1'b0;
  logic ext_fwd = 1'b0, ext_rev = 1'b0;
  logic [1:0] param_freq_src = 2'h3;
  logic [11:0] voltage_analog_in = 12'h000, current_analog_in = 12'h000;
  logic [11:0] aux_analog_in = 12'h000;
  logic freq_resolution = 1'b0;
  logic [15:0] analog_freq_raw = 16'h0;
  logic [29:0] factory_code;
  logic [3:0] step_speed_sel;
  logic [1:0] ramp_set_sel, freq_src;
  logic [2:0] aux_motor_disable;
  logic fault_reset, ramp_hold, output_disable, speed_search, freq_up;
  logic freq_down, counter_clear, seq_start, seq_pause, estop;
  logic external_fault_code, cmd_from_terminals, linear_ramp;
  logic run_fwd, run_rev;
  logic [35:0] analog_filtered;
  logic [15:0] analog_freq_cmd;
  int miscompares = 0, checks_done = 0, nu, nd;
  mfi_contacts mfi_contacts_inst (.core_clk, .closed, .prog_input);
  mfi_decoder mfi_decoder_inst (.core_clk, .sys_rst, .prog_input,
    .func_code, .factory_reset, .fault_cleared, .keypad_reset,
    .speed_search_done, .seq_running, .param_freq_src, .param_cmd_ext,
    .auto_ramp_param, .bipolar_mode, .ext_fwd, .ext_rev,
    .voltage_analog_in, .current_analog_in, .aux_analog_in,
    .analog_delay, .freq_resolution, .analog_freq_raw, .factory_code,
    .step_speed_sel, .fault_reset, .ramp_hold, .ramp_set_sel,
    .output_disable, .speed_search, .freq_up, .freq_down, .counter_clear,
    .seq_start, .seq_pause, .aux_motor_disable, .estop,
    .external_fault_code, .freq_src, .cmd_from_terminals, .linear_ramp,
    .analog_filtered, .analog_freq_cmd, .run_fwd, .run_rev);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task automatic pulses(input logic [5:0] c, output int u, output int d);
    u = 0;
    d = 0;
    closed = c;
    repeat (8) begin
      wait_cyc(1);
      if (freq_up === 1'b1) u++;
      if (freq_down === 1'b1) d++;
    end
  endtask : pulses
  task automatic print_verdict;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50us;
    miscompares++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    wait_cyc(6);
    sys_rst = 0;
    wait_cyc(2);
    foreach (rows[i]) begin
      func_code = rows[i].fc;
      closed = rows[i].cl;
      wait_cyc(3);
      `CHK(step_speed_sel, rows[i].step)
      `CHK(ramp_set_sel, rows[i].ramp)
      `CHK(aux_motor_disable, rows[i].aux)
      `CHK({ramp_hold, output_disable, counter_clear, cmd_from_terminals},
        rows[i].flg)
    end
    sys_rst = 1;
    wait_cyc(1);
    `CHK({step_speed_sel, counter_clear}, 5'h0)
    sys_rst = 0;
    factory_reset = 1;
    wait_cyc(4);
    `CHK(factory_code, {5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01})
    factory_reset = 0;
    func_code = {20'h0, 5'h0c, 5'h0b};
    for (int k = 0; k < 3; k++) begin
      pulses(6'h0, nu, nd);
      pulses(upd_pat[k], nu, nd);
      `CHK(nu, int'(k == 0))
      `CHK(nd, int'(k == 2))
    end
    func_code = {20'h0, 5'h05, 5'h13};
    closed = 6'h1;
    wait_cyc(3);
    `CHK({estop, external_fault_code}, 2'h3)
    closed = 6'h0;
    wait_cyc(3);
    `CHK(estop, 1'b1)
    fault_cleared = 1;
    closed = 6'h2;
    wait_cyc(3);
    `CHK({estop, fault_reset}, 2'h1)
    func_code = {25'h0, 5'h14};
    closed = 6'h0;
    wait_cyc(3);
    `CHK(estop, 1'b1)
    closed = 6'h1;
    keypad_reset = 1;
    wait_cyc(2);
    keypad_reset = 0;
    wait_cyc(2);
    `CHK({estop, external_fault_code}, 2'h0)
    fault_cleared = 0;
    func_code = {25'h0, 5'h09};
    wait_cyc(3);
    `CHK({output_disable, speed_search}, 2'h2)
    closed = 6'h0;
    wait_cyc(3);
    `CHK({output_disable, speed_search}, 2'h1)
    speed_search_done = 1;
    wait_cyc(3);
    `CHK(speed_search, 1'b0)
    speed_search_done = 0;
    func_code = {15'h0, 5'h18, 5'h16, 5'h15};
    for (int k = 0; k < 4; k++) begin
      closed = 6'h4 | 6'(k);
      wait_cyc(3);
      `CHK({freq_src, linear_ramp}, {src_exp[k], 1'b1})
    end
    func_code = 30'h0;
    param_cmd_ext = 1;
    wait_cyc(3);
    `CHK({freq_src, cmd_from_terminals, linear_ramp}, 4'he)
    analog_freq_raw = 16'h04d7;
    freq_resolution = 1;
    wait_cyc(3);
    `CHK(analog_freq_cmd, 16'h04ce)
    freq_resolution = 0;
    wait_cyc(3);
    `CHK(analog_freq_cmd, 16'h04d7)
    analog_delay = {10'h0, 10'h1, 10'h0};
    voltage_analog_in = 12'h5a5;
    current_analog_in = 12'h3c3;
    aux_analog_in = 12'h0f0;
    wait_cyc(8);
    `CHK(analog_filtered, {12'h0f0, 12'h000, 12'h5a5})
    // Sequence start is a one-cycle pulse; pause needs a running program
    closed = 6'h0;
    wait_cyc(2);
    func_code = {20'h0, 5'h0f, 5'h0e};
    seq_running = 1'b1;
    closed = 6'h3;
    wait_cyc(2);
    `CHK({seq_start, seq_pause}, 2'h3)
    wait_cyc(1);
    `CHK({seq_start, seq_pause}, 2'h1)
    seq_running = 1'b0;
    wait_cyc(2);
    `CHK({seq_start, seq_pause}, 2'h0)
    // Bipolar pot overrides the external direction terminals
    bipolar_mode = 1'b1;
    ext_fwd = 1'b1;
    wait_cyc(2);
    `CHK({run_fwd, run_rev}, 2'h1)
    voltage_analog_in = 12'h800;
    wait_cyc(2);
    `CHK({run_fwd, run_rev}, 2'h0)
    voltage_analog_in = 12'hc00;
    ext_fwd = 1'b0;
    ext_rev = 1'b1;
    wait_cyc(2);
    `CHK({run_fwd, run_rev}, 2'h2)
    bipolar_mode = 1'b0;
    wait_cyc(2);
    `CHK({run_fwd, run_rev}, 2'h1)
    print_verdict();
  end
endmodule : mfi_decoder_test
bind mfi_decoder mfi_decoder_asserts mfi_decoder_asserts_inst (
  .core_clk, .sys_rst, .prog_input, .func_code, .keypad_reset,
  .factory_reset, .factory_code, .step_speed_sel, .ramp_hold,
  .ramp_set_sel, .output_disable, .freq_up, .freq_down, .counter_clear,
  .aux_motor_disable, .estop, .external_fault_code);
`default_nettype wire

// >>> verilog/mfi_consts.svh
// Constants of the multi-function input decoder
`ifndef MFI_CONSTS_SVH
`define MFI_CONSTS_SVH

`define MFI_NUM_TERM 6
`define MFI_CODE_W 5
// Function codes
`define MFI_FN_NONE 5'h00
`define MFI_FN_STEP1 5'h01
`define MFI_FN_STEP2 5'h02
`define MFI_FN_STEP3 5'h03
`define MFI_FN_STEP4 5'h04
`define MFI_FN_RESET 5'h05
`define MFI_FN_HOLD 5'h06
`define MFI_FN_RAMP1 5'h07
`define MFI_FN_RAMP2 5'h08
`define MFI_FN_BB_NO 5'h09
`define MFI_FN_BB_NC 5'h0a
`define MFI_FN_UP 5'h0b
`define MFI_FN_DOWN 5'h0c
`define MFI_FN_CNT_CLR 5'h0d
`define MFI_FN_SEQ_RUN 5'h0e
`define MFI_FN_SEQ_PAUSE 5'h0f
`define MFI_FN_AUX1 5'h10
`define MFI_FN_AUX2 5'h11
`define MFI_FN_AUX3 5'h12
`define MFI_FN_ESTOP_NO 5'h13
`define MFI_FN_ESTOP_NC 5'h14
`define MFI_FN_SRC_CUR 5'h15
`define MFI_FN_SRC_AUX 5'h16
`define MFI_FN_CMD_EXT 5'h17
`define MFI_FN_LINEAR 5'h18
// Up/down repeat period while held, 100 ms
`define MFI_REPEAT_MS 100
`define MFI_CLK_KHZ 100000
`define MFI_REPEAT_CYC (`MFI_REPEAT_MS * `MFI_CLK_KHZ)
// Analog filter: one delay unit is 10 ms
`define MFI_DELAY_UNIT_MS 10
`define MFI_DELAY_UNIT_CYC (`MFI_DELAY_UNIT_MS * `MFI_CLK_KHZ)
`define MFI_DELAY_W 10
`define MFI_DELAY_MAX 10'h3e8
`define MFI_DELAY_DEFAULT 10'h005
`define MFI_ADC_W 12
`define MFI_ADC_MID 12'h800
// Resolution: 0 gives 0.01 Hz, 1 gives 0.1 Hz
`define MFI_FREQ_W 16
`define MFI_COARSE_DIV 16'h000a
`endif

// >>> verilog/mfi_decoder.sv
// Multi-function input terminal decoder with analog filters
`timescale 1ns/10ps
`default_nettype none
`include "mfi_consts.svh"

// Contract
// - Code zero terminal has no effect at any level.
// - Codes 1-4 select one of fifteen step speeds; 16 speeds total.
// - Code 5 is normally-open fault reset, like keypad reset.
// - Code 6 freezes ramping, holding present speed.
// - Codes 7 and 8 select one of four ramp time sets.
// - Codes 9/10 base block disables output; motor coasts.
// - Base block release runs speed search, then accelerates to master.
// - Codes 11/12 step master frequency per press and repeatedly held.
// - Up and down together make no change.
// - Code 13 clears and holds the event counter while active.
// - Code 14 starts the internal step sequence.
// - Code 15 pauses the running sequence.
// - Codes 16-18 suppress auxiliary motor outputs one to three.
// - Codes 19/20 emergency stop, latch fault until reset after clear.
// - Codes 21/22 choose current or aux input over parameter source.
// - Code 23 chooses terminal or keypad run commands.
// - Code 24 forces linear ramps, disables automatic ramp mode.
// - Each analog input has delay 0 to 10 s, 0.01 s steps.
// - Resolution 0 gives 0.01 Hz, 1 gives 0.1 Hz steps.
// - Factory reset sets terminals one to six to codes 1 to 6.
// - Bipolar mode idles mid-scale, ignores external direction terminals.
// - Codes 1-4 weight bits 0-3; zero selects master frequency.
// - Code 7 low bit, code 8 high bit of ramp select.
// - Both source codes on: voltage, then current, then aux.
module mfi_decoder (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`MFI_NUM_TERM-1:0] prog_input,
  input wire logic [`MFI_NUM_TERM*`MFI_CODE_W-1:0] func_code,
  input wire logic factory_reset,
  input wire logic fault_cleared,
  input wire logic keypad_reset,
  input wire logic speed_search_done,
  input wire logic seq_running,
  input wire logic [1:0] param_freq_src,
  input wire logic param_cmd_ext,
  input wire logic auto_ramp_param,
  input wire logic bipolar_mode,
  input wire logic ext_fwd,
  input wire logic ext_rev,
  input wire logic [`MFI_ADC_W-1:0] voltage_analog_in,
  input wire logic [`MFI_ADC_W-1:0] current_analog_in,
  input wire logic [`MFI_ADC_W-1:0] aux_analog_in,
  input wire logic [3*`MFI_DELAY_W-1:0] analog_delay,
  input wire logic freq_resolution,
  input wire logic [`MFI_FREQ_W-1:0] analog_freq_raw,
  output logic [`MFI_NUM_TERM*`MFI_CODE_W-1:0] factory_code,
  output logic [3:0] step_speed_sel,
  output logic fault_reset,
  output logic ramp_hold,
  output logic [1:0] ramp_set_sel,
  output logic output_disable,
  output logic speed_search,
  output logic freq_up,
  output logic freq_down,
  output logic counter_clear,
  output logic seq_start,
  output logic seq_pause,
  output logic [2:0] aux_motor_disable,
  output logic estop,
  output logic external_fault_code,
  output logic [1:0] freq_src,
  output logic cmd_from_terminals,
  output logic linear_ramp,
  output logic [3*`MFI_ADC_W-1:0] analog_filtered,
  output logic [`MFI_FREQ_W-1:0] analog_freq_cmd,
  output logic run_fwd,
  output logic run_rev
);

  // ------------------------------------------------------------
  // Action routing
  // ------------------------------------------------------------
  logic [24:0] act;
  logic [24:0] assigned;
  logic [4:0] code [`MFI_NUM_TERM];
  genvar t;
  generate
    for (t = 0; t < `MFI_NUM_TERM; t++) begin : g_code
      assign code[t] = func_code[t*`MFI_CODE_W +: `MFI_CODE_W];
    end
  endgenerate

  always_comb begin
    act = '0;
    assigned = '0;
    for (int i = 0; i < `MFI_NUM_TERM; i++) begin
      if (code[i] != `MFI_FN_NONE && code[i] <= `MFI_FN_LINEAR) begin
        assigned[code[i]] = 1'b1;
        // Closed-contact variants are active when the contact opens
        if (code[i] == `MFI_FN_BB_NC || code[i] == `MFI_FN_ESTOP_NC) begin
          act[code[i]] = act[code[i]] | ~prog_input[i];
        end else begin
          act[code[i]] = act[code[i]] | prog_input[i];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Edge, repeat and latch state
  // ------------------------------------------------------------
  logic up_q, up_d, dn_q, dn_d, run_q, run_d;
  logic [23:0] rep_q, rep_d;
  logic ef_q, ef_d;
  logic freq_up_d, freq_down_d, seq_start_d;
  mfi_pkg::mfi_bb_type bb_q, bb_d;
  logic reset_req;
  logic bb_in, es_in, inc, dec;

  always_comb begin
    bb_in = act[`MFI_FN_BB_NO] | act[`MFI_FN_BB_NC];
    es_in = act[`MFI_FN_ESTOP_NO] | act[`MFI_FN_ESTOP_NC];
    reset_req = act[`MFI_FN_RESET] | keypad_reset;
    inc = act[`MFI_FN_UP] & ~act[`MFI_FN_DOWN];
    dec = act[`MFI_FN_DOWN] & ~act[`MFI_FN_UP];
    up_d = inc;
    dn_d = dec;
    freq_up_d = 1'b0;
    freq_down_d = 1'b0;
    rep_d = '0;
    if (inc || dec) begin
      rep_d = rep_q + 24'h000001;
      if (rep_q == 24'(`MFI_REPEAT_CYC - 1)) begin
        rep_d = '0;
      end
      // Pulse on press, then once per repeat period while held
      freq_up_d = inc & (~up_q | rep_q == 24'(`MFI_REPEAT_CYC - 1));
      freq_down_d = dec & (~dn_q | rep_q == 24'(`MFI_REPEAT_CYC - 1));
      if (~up_q && ~dn_q) begin
        rep_d = '0;
      end
    end
    run_d = act[`MFI_FN_SEQ_RUN];
    seq_start_d = act[`MFI_FN_SEQ_RUN] & ~run_q;
    // Fault stays latched while input is active; set wins over reset
    ef_d = ef_q;
    if (reset_req && fault_cleared) begin
      ef_d = 1'b0;
    end
    if (es_in) begin
      ef_d = 1'b1;
    end
    bb_d = bb_q;
    unique case (bb_q)
      mfi_pkg::MFI_BB_IDLE: if (bb_in) bb_d = mfi_pkg::MFI_BB_BLOCK;
      mfi_pkg::MFI_BB_BLOCK: if (!bb_in) bb_d = mfi_pkg::MFI_BB_SEARCH;
      mfi_pkg::MFI_BB_SEARCH: begin
        if (bb_in) begin
          bb_d = mfi_pkg::MFI_BB_BLOCK;
        end else if (speed_search_done) begin
          bb_d = mfi_pkg::MFI_BB_IDLE;
        end
      end
      default: bb_d = mfi_pkg::MFI_BB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      run_q <= 1'b0;
      rep_q <= '0;
      ef_q <= 1'b0;
      bb_q <= mfi_pkg::MFI_BB_IDLE;
    end else begin
      up_q <= up_d;
      dn_q <= dn_d;
      run_q <= run_d;
      rep_q <= rep_d;
      ef_q <= ef_d;
      bb_q <= bb_d;
    end
  end

  // ------------------------------------------------------------
  // Registered decoded outputs
  // ------------------------------------------------------------
  logic [1:0] src_d;
  logic [`MFI_NUM_TERM*`MFI_CODE_W-1:0] factory_code_d;
  logic [3:0] step_speed_sel_d;
  logic [1:0] ramp_set_sel_d;
  logic [2:0] aux_motor_disable_d;
  logic fault_reset_d, ramp_hold_d, output_disable_d, speed_search_d;
  logic counter_clear_d, seq_pause_d, estop_d, cmd_from_terminals_d;
  logic linear_ramp_d, run_fwd_d, run_rev_d;
  always_comb begin
    src_d = param_freq_src;
    if (assigned[`MFI_FN_SRC_CUR] || assigned[`MFI_FN_SRC_AUX]) begin
      if (act[`MFI_FN_SRC_CUR] && act[`MFI_FN_SRC_AUX]) begin
        src_d = 2'(mfi_pkg::MFI_SRC_VOLT);
      end else if (act[`MFI_FN_SRC_CUR]) begin
        src_d = 2'(mfi_pkg::MFI_SRC_CUR);
      end else if (act[`MFI_FN_SRC_AUX]) begin
        src_d = 2'(mfi_pkg::MFI_SRC_AUX);
      end else begin
        src_d = 2'(mfi_pkg::MFI_SRC_VOLT);
      end
    end
    factory_code_d = factory_code;
    if (factory_reset) begin
      factory_code_d = {`MFI_FN_RESET + 5'h01, `MFI_FN_RESET,
                        `MFI_FN_STEP4, `MFI_FN_STEP3,
                        `MFI_FN_STEP2, `MFI_FN_STEP1};
    end
    step_speed_sel_d = {act[`MFI_FN_STEP4], act[`MFI_FN_STEP3],
                        act[`MFI_FN_STEP2], act[`MFI_FN_STEP1]};
    fault_reset_d = reset_req;
    ramp_hold_d = act[`MFI_FN_HOLD];
    ramp_set_sel_d = {act[`MFI_FN_RAMP2],
                      act[`MFI_FN_RAMP1]};
    output_disable_d = bb_d == mfi_pkg::MFI_BB_BLOCK;
    speed_search_d = bb_d == mfi_pkg::MFI_BB_SEARCH;
    counter_clear_d = act[`MFI_FN_CNT_CLR];
    seq_pause_d = act[`MFI_FN_SEQ_PAUSE] & seq_running;
    aux_motor_disable_d = act[`MFI_FN_AUX3:`MFI_FN_AUX1];
    estop_d = es_in | ef_d;
    cmd_from_terminals_d = assigned[`MFI_FN_CMD_EXT] ?
                           act[`MFI_FN_CMD_EXT] : param_cmd_ext;
    linear_ramp_d = act[`MFI_FN_LINEAR] | ~auto_ramp_param;
    // Bipolar pot: direction from analog side of mid-scale only
    run_fwd_d = ext_fwd & ~ext_rev;
    run_rev_d = ext_rev & ~ext_fwd;
    if (bipolar_mode) begin
      run_fwd_d = voltage_analog_in > `MFI_ADC_MID;
      run_rev_d = voltage_analog_in < `MFI_ADC_MID;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      factory_code <= '0;
      step_speed_sel <= 4'h0;
      fault_reset <= 1'b0;
      ramp_hold <= 1'b0;
      ramp_set_sel <= 2'h0;
      output_disable <= 1'b0;
      speed_search <= 1'b0;
      freq_up <= 1'b0;
      freq_down <= 1'b0;
      counter_clear <= 1'b0;
      seq_start <= 1'b0;
      seq_pause <= 1'b0;
      aux_motor_disable <= 3'h0;
      estop <= 1'b0;
      external_fault_code <= 1'b0;
      freq_src <= 2'h0;
      cmd_from_terminals <= 1'b0;
      linear_ramp <= 1'b0;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
    end else begin
      factory_code <= factory_code_d;
      step_speed_sel <= step_speed_sel_d;
      fault_reset <= fault_reset_d;
      ramp_hold <= ramp_hold_d;
      ramp_set_sel <= ramp_set_sel_d;
      output_disable <= output_disable_d;
      speed_search <= speed_search_d;
      freq_up <= freq_up_d;
      freq_down <= freq_down_d;
      counter_clear <= counter_clear_d;
      seq_start <= seq_start_d;
      seq_pause <= seq_pause_d;
      aux_motor_disable <= aux_motor_disable_d;
      estop <= estop_d;
      external_fault_code <= ef_d;
      freq_src <= src_d;
      cmd_from_terminals <= cmd_from_terminals_d;
      linear_ramp <= linear_ramp_d;
      run_fwd <= run_fwd_d;
      run_rev <= run_rev_d;
    end
  end

  // ------------------------------------------------------------
  // Analog input delay filters
  // ------------------------------------------------------------
  logic [`MFI_ADC_W-1:0] ain [3];
  assign ain[0] = voltage_analog_in;
  assign ain[1] = current_analog_in;
  assign ain[2] = aux_analog_in;

  generate
    for (t = 0; t < 3; t++) begin : g_filt
      // Input must stay steady for the whole delay before it is passed
      logic [`MFI_ADC_W-1:0] held_q, held_d, out_q, out_d;
      logic [19:0] tick_q, tick_d;
      logic [`MFI_DELAY_W-1:0] units_q, units_d, lim;
      always_comb begin
        lim = analog_delay[t*`MFI_DELAY_W +: `MFI_DELAY_W];
        if (lim > `MFI_DELAY_MAX) begin
          lim = `MFI_DELAY_MAX;
        end
        held_d = ain[t];
        out_d = out_q;
        tick_d = tick_q;
        units_d = units_q;
        if (ain[t] != held_q) begin
          tick_d = '0;
          units_d = '0;
        end else if (units_q >= lim) begin
          out_d = held_q;
        end else if (tick_q == 20'(`MFI_DELAY_UNIT_CYC - 1)) begin
          tick_d = '0;
          units_d = units_q + 10'h001;
        end else begin
          tick_d = tick_q + 20'h00001;
        end
      end
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          held_q <= '0;
          out_q <= '0;
          tick_q <= '0;
          units_q <= '0;
        end else begin
          held_q <= held_d;
          out_q <= out_d;
          tick_q <= tick_d;
          units_q <= units_d;
        end
      end
      assign analog_filtered[t*`MFI_ADC_W +: `MFI_ADC_W] = out_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // Frequency resolution
  // ------------------------------------------------------------
  logic [`MFI_FREQ_W-1:0] coarse;
  logic [`MFI_FREQ_W-1:0] analog_freq_cmd_d;
  always_comb begin
    coarse = 16'((analog_freq_raw / `MFI_COARSE_DIV) * `MFI_COARSE_DIV);
    analog_freq_cmd_d = freq_resolution ? coarse : analog_freq_raw;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_freq_cmd <= '0;
    end else begin
      analog_freq_cmd <= analog_freq_cmd_d;
    end
  end

endmodule : mfi_decoder
`default_nettype wire

// >>> verilog/mfi_pkg.sv
// Types of the multi-function input decoder
package mfi_pkg;
  typedef enum logic [1:0] {
    MFI_SRC_VOLT,
    MFI_SRC_CUR,
    MFI_SRC_AUX,
    MFI_SRC_PARAM
  } mfi_src_type;
  typedef enum logic [1:0] {
    MFI_BB_IDLE,
    MFI_BB_BLOCK,
    MFI_BB_SEARCH
  } mfi_bb_type;
endpackage : mfi_pkg
